// *** logic/ccr_cfg.svh ***
/*
  Constants of the core register and interrupt entry block: register
  offsets, reset values, field positions and sequencing counts.
  Assumes it is included by bare name from the block's design file.
*/
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCR_OFS_SP 8'h81
`define CCR_OFS_DPL 8'h82
`define CCR_OFS_DPH 8'h83
`define CCR_OFS_IE 8'hA8
`define CCR_OFS_IP 8'hB8
`define CCR_OFS_PSW 8'hD0
`define CCR_OFS_ACC 8'hE0
`define CCR_OFS_EIE1 8'hE6
`define CCR_OFS_EXTENDED_IRQ_ENABLE_TWO 8'hE7
`define CCR_OFS_B 8'hF0
`define CCR_OFS_EIP1 8'hF6
`define CCR_OFS_EIP2 8'hF7

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCR_RST_SP 8'h07
`define CCR_RST_BYTE 8'h00
`define CCR_RST_SRC 22'h000000

// ----------------------------------------
// status word fields
// ----------------------------------------
`define CCR_PSW_CY 7
`define CCR_PSW_AC 6
`define CCR_PSW_UFA 5
`define CCR_PSW_RS_HI 4
`define CCR_PSW_RS_LO 3
`define CCR_PSW_OV 2
`define CCR_PSW_UFB 1
`define CCR_PSW_PAR 0

// ----------------------------------------
// interrupt sources and entry
// ----------------------------------------
`define CCR_NUM_SRC 22
`define CCR_IE_GLOBAL 7
`define CCR_IE_SRC_BITS 6
`define CCR_VEC_BASE 16'h0003
`define CCR_VEC_SHIFT 3
`define CCR_AUTO_CLR 22'h000005
`define CCR_CALL_CYCLES 4

`endif

// *** logic/ccr_pkg.sv ***
/*
  Types of the core register and interrupt entry block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ccr_pkg;

  // arithmetic operation applied this cycle
  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_ADD,
    ALU_ADD_WITH_CARRY,
    ALU_SUBTRACT_WITH_BORROW,
    ALU_MUL,
    ALU_DIV
  } ccr_alu_op_t;

  // entry and return sequencer
  typedef enum {
    ST_RUN,
    ST_CALL1,
    ST_CALL2,
    ST_CALL3,
    ST_CALL4,
    ST_RET1,
    ST_RET2
  } ccr_state_t;

endpackage
`default_nettype wire

// *** logic/ccr_core_regs.sv ***
/*
  Architectural registers of a small microcontroller core (stack pointer,
  data pointer, status word, accumulators) with interrupt request
  selection, long call entry and return from interrupt.
  Assumes one clock, a register port with read data one cycle later, a
  stack memory with combinational read, and a core that stalls on hold.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ccr_cfg.svh"

module ccr_core_regs (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // arithmetic
  input wire ccr_pkg::ccr_alu_op_t i_alu_op,
  input wire logic [7:0] i_alu_operand,
  // stack memory
  input wire logic i_push,
  input wire logic [7:0] i_push_data,
  input wire logic i_pop,
  input wire logic [7:0] i_stack_rdata,
  output logic [7:0] o_stack_addr,
  output logic [7:0] o_stack_wdata,
  output logic o_stack_we,
  // pointers and status
  output logic [15:0] o_data_pointer,
  input wire logic [2:0] i_work_reg,
  output logic [4:0] o_work_reg_addr,
  output logic [7:0] o_program_status_word,
  // interrupt sources
  input wire logic [21:0] i_irq_pending,
  output logic [21:0] o_irq_clear,
  // core sequencing
  input wire logic i_instr_done,
  input wire logic i_return_from_interrupt,
  input wire logic [15:0] i_next_pc,
  output logic o_core_hold,
  output logic o_vector_valid,
  output logic [15:0] o_vector_addr,
  output logic o_resume_valid,
  output logic [15:0] o_resume_pc
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // add or subtract with carry in: {carry, aux, overflow, result}
  function automatic logic [10:0] ccr_addsub(input logic [7:0] a, input logic [7:0] b,
                                             input logic cin, input logic sub);
    logic [7:0] bb;
    logic c;
    logic [8:0] full;
    logic [4:0] low;
    logic ov;
    bb = sub ? ~b : b;
    c = sub ? ~cin : cin;
    full = {1'b0, a} + {1'b0, bb} + {8'h00, c};
    low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, c};
    ov = (a[7] == bb[7]) && (full[7] != a[7]);
    return {full[8] ^ sub, low[4] ^ sub, ov, full[7:0]};
  endfunction

  // lowest numbered set source: {found, index}
  function automatic logic [5:0] ccr_pick(input logic [21:0] m);
    logic [5:0] r;
    r = 6'h00;
    for (int i = `CCR_NUM_SRC - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  ccr_pkg::ccr_state_t state_ff;
  ccr_pkg::ccr_state_t nxt_state;
  logic [7:0] stack_pointer_ff;
  logic [7:0] data_pointer_low_ff;
  logic [7:0] data_pointer_high_ff;
  logic [7:0] accumulator_ff;
  logic [7:0] second_accumulator_ff;
  logic carry_flag_ff;
  logic aux_carry_flag_ff;
  logic overflow_flag_ff;
  logic user_flag_a_ff;
  logic user_flag_b_ff;
  logic [1:0] bank_select_ff;
  logic global_irq_enable_ff;
  logic [21:0] src_enable_ff;
  logic [21:0] src_high_prio_ff;
  logic req_ff;
  logic req_high_ff;
  logic [4:0] req_src_ff;
  logic call_high_ff;
  logic [4:0] call_src_ff;
  logic [15:0] ret_pc_ff;
  logic [7:0] resume_high_ff;
  logic active_high_ff;
  logic active_low_ff;
  logic parity;
  logic [7:0] psw_view;
  logic reg_wr_hit;
  logic take_call;

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  logic alu_upd;
  logic [7:0] nxt_acc;
  logic [7:0] nxt_b;
  logic nxt_cy;
  logic nxt_ac;
  logic nxt_ov;
  logic [10:0] sum;
  logic [15:0] prod;

  always_comb begin
    sum = 11'h000;
    prod = 16'(accumulator_ff) * 16'(second_accumulator_ff);
    alu_upd = 1'b1;
    nxt_acc = accumulator_ff;
    nxt_b = second_accumulator_ff;
    nxt_cy = 1'b0;
    nxt_ac = 1'b0;
    nxt_ov = 1'b0;
    case (i_alu_op)
      ccr_pkg::ALU_ADD, ccr_pkg::ALU_ADD_WITH_CARRY, ccr_pkg::ALU_SUBTRACT_WITH_BORROW: begin
        sum = ccr_addsub(accumulator_ff, i_alu_operand,
                         (i_alu_op != ccr_pkg::ALU_ADD) && carry_flag_ff,
                         i_alu_op == ccr_pkg::ALU_SUBTRACT_WITH_BORROW);
        nxt_acc = sum[7:0];
        nxt_cy = sum[10];
        nxt_ac = sum[9];
        nxt_ov = sum[8];
      end
      ccr_pkg::ALU_MUL: begin
        nxt_acc = prod[7:0];
        nxt_b = prod[15:8];
        nxt_ov = |prod[15:8];
      end
      ccr_pkg::ALU_DIV: begin
        if (second_accumulator_ff == 8'h00) begin
          nxt_ov = 1'b1;
        end else begin
          nxt_acc = accumulator_ff / second_accumulator_ff;
          nxt_b = accumulator_ff % second_accumulator_ff;
        end
      end
      default: begin
        alu_upd = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // accumulators and status word
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      accumulator_ff <= `CCR_RST_BYTE;
      second_accumulator_ff <= `CCR_RST_BYTE;
    end else if (alu_upd) begin
      accumulator_ff <= nxt_acc;
      second_accumulator_ff <= nxt_b;
    end else if (reg_wr_hit && i_reg_addr == `CCR_OFS_ACC) begin
      accumulator_ff <= i_reg_wdata;
    end else if (reg_wr_hit && i_reg_addr == `CCR_OFS_B) begin
      second_accumulator_ff <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      carry_flag_ff <= 1'b0;
      aux_carry_flag_ff <= 1'b0;
      overflow_flag_ff <= 1'b0;
    end else if (alu_upd) begin
      carry_flag_ff <= nxt_cy;
      aux_carry_flag_ff <= nxt_ac;
      overflow_flag_ff <= nxt_ov;
    end else if (reg_wr_hit && i_reg_addr == `CCR_OFS_PSW) begin
      carry_flag_ff <= i_reg_wdata[`CCR_PSW_CY];
      aux_carry_flag_ff <= i_reg_wdata[`CCR_PSW_AC];
      overflow_flag_ff <= i_reg_wdata[`CCR_PSW_OV];
    end
  end

  // user flags and bank select change only by software
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      user_flag_a_ff <= 1'b0;
      user_flag_b_ff <= 1'b0;
      bank_select_ff <= 2'h0;
    end else if (reg_wr_hit && i_reg_addr == `CCR_OFS_PSW) begin
      user_flag_a_ff <= i_reg_wdata[`CCR_PSW_UFA];
      user_flag_b_ff <= i_reg_wdata[`CCR_PSW_UFB];
      bank_select_ff <= i_reg_wdata[`CCR_PSW_RS_HI:`CCR_PSW_RS_LO];
    end
  end

  assign parity = ^accumulator_ff;
  assign psw_view = {carry_flag_ff, aux_carry_flag_ff, user_flag_a_ff, bank_select_ff,
                     overflow_flag_ff, user_flag_b_ff, parity};
  assign o_program_status_word = psw_view;
  assign o_work_reg_addr = {bank_select_ff, i_work_reg};

  // ----------------------------------------
  // data pointer
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      data_pointer_low_ff <= `CCR_RST_BYTE;
      data_pointer_high_ff <= `CCR_RST_BYTE;
    end else if (reg_wr_hit && i_reg_addr == `CCR_OFS_DPL) begin
      data_pointer_low_ff <= i_reg_wdata;
    end else if (reg_wr_hit && i_reg_addr == `CCR_OFS_DPH) begin
      data_pointer_high_ff <= i_reg_wdata;
    end
  end

  assign o_data_pointer = {data_pointer_high_ff, data_pointer_low_ff};

  // ----------------------------------------
  // interrupt enables and priorities
  // ----------------------------------------
  assign reg_wr_hit = i_reg_wr;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      global_irq_enable_ff <= 1'b0;
      src_enable_ff <= `CCR_RST_SRC;
      src_high_prio_ff <= `CCR_RST_SRC;
    end else if (reg_wr_hit) begin
      case (i_reg_addr)
        `CCR_OFS_IE: begin
          global_irq_enable_ff <= i_reg_wdata[`CCR_IE_GLOBAL];
          src_enable_ff[5:0] <= i_reg_wdata[`CCR_IE_SRC_BITS-1:0];
        end
        `CCR_OFS_EIE1: src_enable_ff[13:6] <= i_reg_wdata;
        `CCR_OFS_EXTENDED_IRQ_ENABLE_TWO: src_enable_ff[21:14] <= i_reg_wdata;
        `CCR_OFS_IP: src_high_prio_ff[5:0] <= i_reg_wdata[`CCR_IE_SRC_BITS-1:0];
        `CCR_OFS_EIP1: src_high_prio_ff[13:6] <= i_reg_wdata;
        `CCR_OFS_EIP2: src_high_prio_ff[21:14] <= i_reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // request detection, one clock
  // ----------------------------------------
  logic [21:0] eligible;
  logic [5:0] pick_high;
  logic [5:0] pick_low;

  assign eligible = i_irq_pending & src_enable_ff & {22{global_irq_enable_ff}};
  assign pick_high = ccr_pick(eligible & src_high_prio_ff);
  assign pick_low = ccr_pick(eligible & ~src_high_prio_ff);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      req_ff <= 1'b0;
      req_high_ff <= 1'b0;
      req_src_ff <= 5'h00;
    end else if (pick_high[5] && !active_high_ff) begin
      req_ff <= 1'b1;
      req_high_ff <= 1'b1;
      req_src_ff <= pick_high[4:0];
    end else if (pick_low[5] && !active_high_ff && !active_low_ff) begin
      req_ff <= 1'b1;
      req_high_ff <= 1'b0;
      req_src_ff <= pick_low[4:0];
    end else begin
      req_ff <= 1'b0;
      req_high_ff <= 1'b0;
      req_src_ff <= 5'h00;
    end
  end

  // ----------------------------------------
  // entry and return sequencer
  // ----------------------------------------
  assign take_call = i_instr_done && !i_return_from_interrupt && req_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ccr_pkg::ST_RUN: begin
        if (i_return_from_interrupt) begin
          nxt_state = ccr_pkg::ST_RET1;
        end else if (take_call) begin
          nxt_state = ccr_pkg::ST_CALL1;
        end
      end
      ccr_pkg::ST_CALL1: nxt_state = ccr_pkg::ST_CALL2;
      ccr_pkg::ST_CALL2: nxt_state = ccr_pkg::ST_CALL3;
      ccr_pkg::ST_CALL3: nxt_state = ccr_pkg::ST_CALL4;
      ccr_pkg::ST_RET1: nxt_state = ccr_pkg::ST_RET2;
      default: nxt_state = ccr_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= ccr_pkg::ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // return address and source latched at the instruction boundary
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ret_pc_ff <= 16'h0000;
      call_src_ff <= 5'h00;
      call_high_ff <= 1'b0;
    end else if (state_ff == ccr_pkg::ST_RUN && !i_return_from_interrupt && take_call) begin
      ret_pc_ff <= i_next_pc;
      call_src_ff <= req_src_ff;
      call_high_ff <= req_high_ff;
    end
  end

  // in-service levels
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      active_high_ff <= 1'b0;
      active_low_ff <= 1'b0;
    end else if (state_ff == ccr_pkg::ST_CALL1) begin
      if (call_high_ff) begin
        active_high_ff <= 1'b1;
      end else begin
        active_low_ff <= 1'b1;
      end
    end else if (state_ff == ccr_pkg::ST_RET2) begin
      if (active_high_ff) begin
        active_high_ff <= 1'b0;
      end else begin
        active_low_ff <= 1'b0;
      end
    end
  end

  assign o_core_hold = state_ff != ccr_pkg::ST_RUN;

  // ----------------------------------------
  // stack pointer and stack port
  // ----------------------------------------
  logic in_call_push;
  logic in_ret_pop;

  assign in_call_push = state_ff == ccr_pkg::ST_CALL1 || state_ff == ccr_pkg::ST_CALL2;
  assign in_ret_pop = state_ff == ccr_pkg::ST_RET1 || state_ff == ccr_pkg::ST_RET2;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      stack_pointer_ff <= `CCR_RST_SP;
    end else if (in_call_push) begin
      stack_pointer_ff <= stack_pointer_ff + 8'h01;
    end else if (in_ret_pop) begin
      stack_pointer_ff <= stack_pointer_ff - 8'h01;
    end else if (state_ff == ccr_pkg::ST_RUN && i_push) begin
      stack_pointer_ff <= stack_pointer_ff + 8'h01;
    end else if (state_ff == ccr_pkg::ST_RUN && i_pop) begin
      stack_pointer_ff <= stack_pointer_ff - 8'h01;
    end else if (reg_wr_hit && i_reg_addr == `CCR_OFS_SP) begin
      stack_pointer_ff <= i_reg_wdata;
    end
  end

  always_comb begin
    o_stack_addr = stack_pointer_ff;
    o_stack_wdata = i_push_data;
    o_stack_we = 1'b0;
    if (in_call_push) begin
      o_stack_addr = stack_pointer_ff + 8'h01;
      o_stack_wdata = (state_ff == ccr_pkg::ST_CALL1) ? ret_pc_ff[7:0] : ret_pc_ff[15:8];
      o_stack_we = 1'b1;
    end else if (state_ff == ccr_pkg::ST_RUN && i_push) begin
      o_stack_addr = stack_pointer_ff + 8'h01;
      o_stack_we = 1'b1;
    end
  end

  // ----------------------------------------
  // vector, flag clear and resume outputs
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_irq_clear <= `CCR_RST_SRC;
      o_vector_valid <= 1'b0;
      o_vector_addr <= 16'h0000;
      o_resume_valid <= 1'b0;
      o_resume_pc <= 16'h0000;
      resume_high_ff <= `CCR_RST_BYTE;
    end else begin
      o_irq_clear <= `CCR_RST_SRC;
      o_vector_valid <= 1'b0;
      o_resume_valid <= 1'b0;
      if (state_ff == ccr_pkg::ST_RUN && !i_return_from_interrupt && take_call) begin
        o_irq_clear <= `CCR_AUTO_CLR & (22'h000001 << req_src_ff);
      end
      if (state_ff == ccr_pkg::ST_CALL3) begin
        o_vector_valid <= 1'b1;
        o_vector_addr <= `CCR_VEC_BASE + ({11'h000, call_src_ff} << `CCR_VEC_SHIFT);
      end
      if (state_ff == ccr_pkg::ST_RET1) begin
        resume_high_ff <= i_stack_rdata;
      end
      if (state_ff == ccr_pkg::ST_RET2) begin
        o_resume_valid <= 1'b1;
        o_resume_pc <= {resume_high_ff, i_stack_rdata};
      end
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reg_rdata <= `CCR_RST_BYTE;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `CCR_OFS_SP: o_reg_rdata <= stack_pointer_ff;
        `CCR_OFS_DPL: o_reg_rdata <= data_pointer_low_ff;
        `CCR_OFS_DPH: o_reg_rdata <= data_pointer_high_ff;
        `CCR_OFS_PSW: o_reg_rdata <= psw_view;
        `CCR_OFS_ACC: o_reg_rdata <= accumulator_ff;
        `CCR_OFS_B: o_reg_rdata <= second_accumulator_ff;
        `CCR_OFS_IE: o_reg_rdata <= {global_irq_enable_ff, 1'b0, src_enable_ff[5:0]};
        `CCR_OFS_EIE1: o_reg_rdata <= src_enable_ff[13:6];
        `CCR_OFS_EXTENDED_IRQ_ENABLE_TWO: o_reg_rdata <= src_enable_ff[21:14];
        `CCR_OFS_IP: o_reg_rdata <= {2'h0, src_high_prio_ff[5:0]};
        `CCR_OFS_EIP1: o_reg_rdata <= src_high_prio_ff[13:6];
        `CCR_OFS_EIP2: o_reg_rdata <= src_high_prio_ff[21:14];
        default: o_reg_rdata <= `CCR_RST_BYTE;
      endcase
    end else begin
      o_reg_rdata <= `CCR_RST_BYTE;
    end
  end

endmodule
`default_nettype wire

// *** test/ccr_chk.sv ***
/*
  Checker of the core register block: stack, entry and return timing.
  Assumes binding to the design top and the constants header on the path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ccr_cfg.svh"

module ccr_chk (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // watched ports
  input wire logic i_push,
  input wire logic [7:0] i_push_data,
  input wire logic [7:0] o_stack_addr,
  input wire logic [7:0] o_stack_wdata,
  input wire logic o_stack_we,
  input wire logic [2:0] i_work_reg,
  input wire logic [4:0] o_work_reg_addr,
  input wire logic [7:0] o_program_status_word,
  input wire logic [21:0] o_irq_clear,
  input wire logic i_instr_done,
  input wire logic i_return_from_interrupt,
  input wire logic [15:0] i_next_pc,
  input wire logic o_core_hold,
  input wire logic o_vector_valid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] pc_lo, pc_hi;
  assign pc_lo = i_next_pc[7:0];
  assign pc_hi = i_next_pc[15:8];
  sequence entry_s;
    $rose(o_core_hold) && o_stack_we;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_SP_RESET: assert property ($fell(i_rst) |-> o_stack_addr == 8'h07)
    else $error("stack pointer not at reset value");
  AST_PUSH_WR: assert property (i_push && !o_core_hold |-> o_stack_we && o_stack_wdata == i_push_data)
    else $error("push byte not written");
  AST_BANK: assert property (o_work_reg_addr == {o_program_status_word[4:3], i_work_reg})
    else $error("working register bank wrong");
  AST_CALL_TIME: assert property (entry_s |-> (o_core_hold && !o_vector_valid)[*3]
    ##1 (o_core_hold && o_vector_valid) ##1 !o_core_hold) else $error("entry timing wrong");
  AST_AFTER_DONE: assert property (entry_s |-> $past(i_instr_done))
    else $error("entry without instruction boundary");
  AST_RET_ADDR: assert property (entry_s |-> o_stack_wdata == $past(pc_lo) ##1 o_stack_we &&
    o_stack_addr == $past(o_stack_addr) + 8'h01 && o_stack_wdata == $past(pc_hi, 2))
    else $error("return address push wrong");
  AST_HW_CLEAR: assert property (o_irq_clear != 22'h000000 |-> $onehot(o_irq_clear) &&
    (o_irq_clear & ~`CCR_AUTO_CLR) == 22'h000000 && $rose(o_core_hold))
    else $error("hardware clear wrong");
  AST_RETURN: assert property (i_return_from_interrupt && !o_core_hold |=>
    (o_core_hold && !o_stack_we)[*2]) else $error("return sequence wrong");
  cover property (entry_s);
  cover property (o_irq_clear != 22'h000000);
  cover property (i_return_from_interrupt ##3 !o_core_hold);
endmodule

bind ccr_core_regs ccr_chk u_chk (.*);
`default_nettype wire

// *** test/ccr_periph.sv ***
/*
  Model of the peripherals that raise pending flags.
  Assumes the bench pulses raise and software clear masks for one cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module ccr_periph (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // events and clears
  input wire logic [21:0] i_raise,
  input wire logic [21:0] i_sw_clear,
  input wire logic [21:0] i_hw_clear,
  // flags
  output logic [21:0] o_pending
);
  // set regardless of enable, cleared by hardware or software
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pending <= 22'h000000;
    end else begin
      o_pending <= (o_pending & ~i_sw_clear & ~i_hw_clear) | i_raise;
    end
  end
endmodule
`default_nettype wire

// *** test/tb_cpu_core_regs_and_irq_entry.sv ***
/*
  Self-checking bench of the core register and interrupt entry block.
  Assumes package, design, checker and peripheral model compile first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ccr_cfg.svh"

module tb_cpu_core_regs_and_irq_entry;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_push = 1'b0;
  logic i_pop = 1'b0, i_instr_done = 1'b0, i_return_from_interrupt = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_alu_operand = 8'h00;
  logic [7:0] i_push_data = 8'h00, i_stack_rdata, o_reg_rdata, o_stack_addr, o_stack_wdata;
  logic [7:0] o_program_status_word, a, b, x, p;
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [7:0] ofs [6] = '{`CCR_OFS_SP, `CCR_OFS_DPL, `CCR_OFS_DPH, `CCR_OFS_PSW,
    `CCR_OFS_ACC, `CCR_OFS_B};
  logic [2:0] i_work_reg = 3'h0;
  logic [4:0] o_work_reg_addr;
  logic [15:0] i_next_pc = 16'h0000, o_data_pointer, o_vector_addr, o_resume_pc;
  logic [21:0] raise = 22'h000000, sw_clr = 22'h000000, i_irq_pending, o_irq_clear;
  logic [23:0] r;
  logic o_stack_we, o_core_hold, o_vector_valid, o_resume_valid;
  ccr_pkg::ccr_alu_op_t i_alu_op = ccr_pkg::ALU_NONE, op;
  int seed = 64, n_mismatch = 0, total_checks = 0, i;

  ccr_core_regs dut (.*);
  ccr_periph u_periph (.i_sys_clk, .i_rst, .i_raise(raise), .i_sw_clear(sw_clr),
    .i_hw_clear(o_irq_clear), .o_pending(i_irq_pending));
  assign i_stack_rdata = mem[o_stack_addr];
  always @(posedge i_sys_clk) begin
    if (o_stack_we === 1'b1) mem[o_stack_addr] <= o_stack_wdata;
  end
  initial begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_mismatch++;
    summarize();
  end

  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= ad;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_reg_addr <= ad;
    i_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 chk("reg_read", 24'(e), 24'(o_reg_rdata));
  endtask
  task automatic pend(input logic [21:0] s, input logic [21:0] c);
    @(posedge i_sys_clk);
    raise <= s;
    sw_clr <= c;
    @(posedge i_sys_clk);
    raise <= 22'h000000;
    sw_clr <= 22'h000000;
  endtask
  task automatic ev(input bit ret, input logic [15:0] pc, input logic [15:0] e, input bit go);
    int k;
    logic [16:0] got;
    got = 17'h00000;
    @(posedge i_sys_clk);
    i_next_pc <= pc;
    if (ret) i_return_from_interrupt <= 1'b1;
    else i_instr_done <= 1'b1;
    @(posedge i_sys_clk);
    i_return_from_interrupt <= 1'b0;
    i_instr_done <= 1'b0;
    for (k = 0; k < 8; k++) begin
      @(posedge i_sys_clk);
      #1;
      if (ret && o_resume_valid === 1'b1) got = {1'b1, o_resume_pc};
      if (!ret && o_vector_valid === 1'b1) got = {1'b1, o_vector_addr};
    end
    chk("sequencer", 24'(go ? {1'b1, e} : 17'h00000), 24'(got));
  endtask
  function automatic logic [23:0] calc(ccr_pkg::ccr_alu_op_t o, logic [7:0] a, logic [7:0] b,
    logic [7:0] x, logic [7:0] p);
    logic [8:0] s;
    logic [4:0] n;
    logic [15:0] m;
    logic c;
    c = (o == ccr_pkg::ALU_ADD) ? 1'b0 : p[7];
    s = 9'h000;
    n = 5'h00;
    m = 16'(a) * 16'(b);
    if (o == ccr_pkg::ALU_SUBTRACT_WITH_BORROW) begin
      s = {1'b0, a} - {1'b0, x} - 9'(c);
      n = {1'b0, a[3:0]} - {1'b0, x[3:0]} - 5'(c);
      p[2] = (a[7] != x[7]) && (s[7] != a[7]);
    end else if (o == ccr_pkg::ALU_ADD || o == ccr_pkg::ALU_ADD_WITH_CARRY) begin
      s = {1'b0, a} + {1'b0, x} + 9'(c);
      n = {1'b0, a[3:0]} + {1'b0, x[3:0]} + 5'(c);
      p[2] = (a[7] == x[7]) && (s[7] != a[7]);
    end else if (o == ccr_pkg::ALU_MUL) begin
      p[2] = m > 16'h00FF;
      {b, s[7:0]} = m;
    end else begin
      p[2] = b == 8'h00;
      s[7:0] = p[2] ? a : a / b;
      b = p[2] ? b : a % b;
    end
    return {s[7:0], b, s[8], n[4], p[5:1], ^s[7:0]};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    for (i = 0; i < 6; i++) rd(ofs[i], (i == 0) ? `CCR_RST_SP : `CCR_RST_BYTE);
    wr(8'hA1, 8'hFF);
    rd(8'hA1, 8'h00);
    for (i = 0; i < 20; i++) begin
      {a, b, x, p} = {$random(seed)};
      op = ccr_pkg::ccr_alu_op_t'(3'(i < 5 ? i + 1 : 1 + $unsigned($random(seed)) % 5));
      if (i == 0) {a, x} = 16'h7F01;
      if (i == 1) {a, x, p} = 24'hFF0080;
      if (i == 2) {a, x} = 16'h0001;
      if (i == 3) {a, b} = 16'hFFFF;
      if (i == 4) b = 8'h00;
      i_work_reg <= 3'($random(seed));
      wr(`CCR_OFS_ACC, a);
      wr(`CCR_OFS_B, b);
      wr(`CCR_OFS_PSW, p);
      wr(`CCR_OFS_DPL, x);
      wr(`CCR_OFS_DPH, p);
      #1 chk("data_pointer", 24'({p, x}), 24'(o_data_pointer));
      chk("bank_psw", 24'({p[4:3], i_work_reg, p[7:1], ^a}), 24'({o_work_reg_addr, o_program_status_word}));
      rd(`CCR_OFS_PSW, {p[7:1], ^a});
      @(posedge i_sys_clk);
      i_alu_op <= op;
      i_alu_operand <= x;
      @(posedge i_sys_clk);
      i_alu_op <= ccr_pkg::ALU_NONE;
      r = calc(op, a, b, x, p);
      rd(`CCR_OFS_ACC, r[23:16]);
      rd(`CCR_OFS_B, r[15:8]);
      rd(`CCR_OFS_PSW, r[7:0]);
    end
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      @(posedge i_sys_clk);
      i_push <= 1'b1;
      i_push_data <= 8'hA0 + 8'(i);
    end
    @(posedge i_sys_clk);
    i_push <= 1'b0;
    i_pop <= 1'b1;
    @(posedge i_sys_clk);
    i_pop <= 1'b0;
    for (i = 0; i < 3; i++) chk("stack_byte", 24'(8'hA0 + 8'(i)), 24'(mem[8 + i]));
    rd(`CCR_OFS_SP, 8'h09);
    $display("test stack done");
    wr(`CCR_OFS_IE, 8'h08);
    pend(22'h000008, 22'h000000);
    ev(0, 16'h0100, 16'h0000, 0);
    wr(`CCR_OFS_IE, 8'h80);
    ev(0, 16'h0101, 16'h0000, 0);
    wr(`CCR_OFS_IE, 8'h88);
    ev(0, 16'h0102, 16'h001B, 1);
    wr(`CCR_OFS_EXTENDED_IRQ_ENABLE_TWO, 8'h80);
    wr(`CCR_OFS_EIP2, 8'h80);
    pend(22'h200000, 22'h000000);
    ev(0, 16'h0200, 16'h00AB, 1);
    pend(22'h000000, 22'h200000);
    ev(1, 16'h0200, 16'h0200, 1);
    ev(0, 16'h0110, 16'h0000, 0);
    ev(1, 16'h0102, 16'h0102, 1);
    ev(0, 16'h0103, 16'h001B, 1);
    pend(22'h000000, 22'h000008);
    ev(1, 16'h0103, 16'h0103, 1);
    ev(0, 16'h0104, 16'h0000, 0);
    wr(`CCR_OFS_IE, 8'h85);
    pend(22'h000005, 22'h000000);
    ev(0, 16'h0300, 16'h0003, 1);
    chk("pending", 24'h000004, 24'(i_irq_pending));
    ev(1, 16'h0300, 16'h0300, 1);
    ev(0, 16'h0301, 16'h0013, 1);
    pend(22'h000000, 22'h000004);
    ev(1, 16'h0301, 16'h0301, 1);
    rd(`CCR_OFS_SP, 8'h09);
    $display("test interrupts done");
    summarize();
  end
endmodule
`default_nettype wire
